// file: src/fcct_core.v
`timescale 1ns/1ps
`include "fcct_defs.vh"
module fcct_core (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_ce,
    input wire i_chip_enable_n,
    input wire i_io_request_n,
    input wire i_read_n,
    input wire i_machine_cycle_one_n,
    input wire i_channel_select_low,
    input wire i_channel_select_high,
    input wire [7:0] i_data,
    input wire i_chain_enable_in,
    input wire i_service_done,
    input wire [3:0] i_ext_clock_trigger,
    output reg [7:0] o_data,
    output reg o_data_oe,
    output reg o_int_request_n,
    output reg o_chain_enable_out,
    output reg [3:0] o_zero_count_pulse
);
    localparam NCH = 4;

    // Returns the lowest set bit index; used for priority and end of service.
    function [2:0] first_set;
        input [3:0] v;
        begin
            if (v[0]) begin
                first_set = 3'b100;
            end else if (v[1]) begin
                first_set = 3'b101;
            end else if (v[2]) begin
                first_set = 3'b110;
            end else if (v[3]) begin
                first_set = 3'b111;
            end else begin
                first_set = 3'b000;
            end
        end
    endfunction

    // Takes the channel number as an integer so that loop indices need no padding.
    function chan_hit;
        input [1:0] sel;
        input integer idx;
        begin
            chan_hit = (sel == idx[1:0]);
        end
    endfunction

    // All bus pins come from the processor's timing, so they are synchronised
    // before use. Data shares the same delay as the strobes it travels with.
    wire [7:0] ctl_s;
    wire [7:0] bus_d;
    wire [3:0] trg_s;

    fcct_sync #(.W(8)) u_sync_ctl (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_async({i_chip_enable_n, i_io_request_n, i_read_n, i_machine_cycle_one_n,
                  i_channel_select_high, i_channel_select_low, i_chain_enable_in,
                  i_service_done}),
        .o_sync(ctl_s)
    );

    fcct_sync #(.W(8)) u_sync_dat (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_async(i_data),
        .o_sync(bus_d)
    );

    fcct_sync #(.W(NCH)) u_sync_trg (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_async(i_ext_clock_trigger),
        .o_sync(trg_s)
    );

    wire ce_n_s = ctl_s[7];
    wire io_request_n_n_s = ctl_s[6];
    wire rd_n_s = ctl_s[5];
    wire m1_n_s = ctl_s[4];
    wire [1:0] bus_cs = ctl_s[3:2];
    wire iei_s = ctl_s[1];
    wire done_s = ctl_s[0];

    wire io_act = !io_request_n_n_s && !ce_n_s && m1_n_s;
    wire wr_act = io_act && rd_n_s;
    wire rd_act = io_act && !rd_n_s;
    wire ack_act = !m1_n_s && !io_request_n_n_s && rd_n_s;
    wire m1_act = !m1_n_s;

    // Strobe and done previous-state flags reset to active (trigger history to 0) so that a strobe already low when
    // reset releases is not mistaken for a fresh cycle.
    reg wr_p_q;
    reg rd_p_q;
    reg ack_p_q;
    reg done_p_q;
    reg [3:0] trg_p_q;

    wire wr_stb = wr_act && !wr_p_q;
    wire rd_stb = rd_act && !rd_p_q;
    wire ack_stb = ack_act && !ack_p_q;
    wire done_stb = done_s && !done_p_q;

    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            wr_p_q <= 1'b1;
            rd_p_q <= 1'b1;
            ack_p_q <= 1'b1;
            done_p_q <= 1'b1;
            trg_p_q <= 4'h0;
        end else if (i_ce) begin
            wr_p_q <= wr_act;
            rd_p_q <= rd_act;
            ack_p_q <= ack_act;
            done_p_q <= done_s;
            trg_p_q <= trg_s;
        end
    end

    wire [NCH-1:0] ip;
    wire [NCH-1:0] ius;
    wire [NCH-1:0] tcn;
    wire [NCH-1:0] zc;
    wire [NCH-1:0] pre_tick;
    wire [8*NCH-1:0] cnt_all;
    wire [NCH:0] en;

    // Daisy chain: a channel passes the enable on only while it is neither
    // pending nor in service, so higher-numbered channels and chained parts wait.
    assign en[0] = iei_s;

    wire [2:0] ack_w = first_set(ip & en[NCH-1:0]);
    wire ack_ok = ack_w[2];
    wire [1:0] ack_idx = ack_w[1:0];
    wire [2:0] done_w = first_set(ius);
    wire done_ok = done_w[2];
    wire [1:0] done_idx = done_w[1:0];

    reg [7:3] vec_q;

    // Vector write only when channel 0 is not expecting a time constant.
    wire vec_wr = wr_stb && chan_hit(bus_cs, 0) && !tcn[0]
        && !bus_d[`FCCT_CW_CTRL];

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : ch
            reg [7:0] ctrl_q;
            reg [7:0] tc_q;
            reg [7:0] cnt_q;
            reg tc_next_q;
            reg run_q;
            reg arm_q;
            reg held_q;
            reg ip_q;
            reg ius_q;
            reg zc_q;

            wire wr_me = wr_stb && chan_hit(bus_cs, g);
            wire is_tc = wr_me && tc_next_q;
            wire is_ctrl = wr_me && !tc_next_q && bus_d[`FCCT_CW_CTRL];
            wire rise = trg_s[g] && !trg_p_q[g];
            wire fall = !trg_s[g] && trg_p_q[g];
            wire edge_hit = ctrl_q[`FCCT_CW_EDGE] ? rise : fall;
            wire counter_mode = ctrl_q[`FCCT_CW_MODE];
            wire tick = run_q && (counter_mode ? edge_hit : pre_tick[g]);
            wire zero = tick && (cnt_q == `FCCT_CNT_ONE);
            wire ev = zero && ctrl_q[`FCCT_CW_INTEN];
            wire ack_me = ack_stb && ack_ok && chan_hit(ack_idx, g);
            wire done_me = done_stb && done_ok && chan_hit(done_idx, g);
            wire dis = is_ctrl && !bus_d[`FCCT_CW_INTEN];

            fcct_presc u_presc (
                .i_ref_clk(i_ref_clk),
                .i_rst(i_rst),
                .i_ce(i_ce),
                .i_run(run_q && !counter_mode),
                .i_sel256(ctrl_q[`FCCT_CW_PRE]),
                .o_tick(pre_tick[g])
            );

            always @(posedge i_ref_clk) begin
                if (i_rst) begin
                    ctrl_q <= `FCCT_CTRL_RST;
                    tc_q <= `FCCT_TC_RST;
                    cnt_q <= `FCCT_TC_RST;
                    tc_next_q <= 1'b0;
                    run_q <= 1'b0;
                    arm_q <= 1'b0;
                    held_q <= 1'b0;
                    ip_q <= 1'b0;
                    ius_q <= 1'b0;
                    zc_q <= 1'b0;
                end else if (i_ce) begin
                    zc_q <= zero;
                    if (is_ctrl) begin
                        // The reset bit is a one-shot and is never stored.
                        ctrl_q <= bus_d & ~(8'h01 << `FCCT_CW_RESET);
                        tc_next_q <= bus_d[`FCCT_CW_TCNEXT];
                    end else if (is_tc) begin
                        tc_q <= bus_d;
                        tc_next_q <= 1'b0;
                    end
                    if (is_ctrl && bus_d[`FCCT_CW_RESET]) begin
                        run_q <= 1'b0;
                        arm_q <= 1'b0;
                    end else if (is_tc && !run_q) begin
                        // Auto start, or wait for a trigger edge in timer mode.
                        if (counter_mode || !ctrl_q[`FCCT_CW_TRIG]) begin
                            run_q <= 1'b1;
                        end else begin
                            arm_q <= 1'b1;
                        end
                    end else if (arm_q && edge_hit) begin
                        // Edge seen after two sync flops; prescaler runs next edge.
                        run_q <= 1'b1;
                        arm_q <= 1'b0;
                    end
                    if (is_tc && !run_q) begin
                        cnt_q <= bus_d;
                    end else if (zero) begin
                        cnt_q <= tc_q;
                    end else if (tick) begin
                        cnt_q <= cnt_q - `FCCT_CNT_ONE;
                    end
                    // Zero events during a machine cycle are held back so the
                    // chain sees stable request status, then applied after.
                    if (m1_act && !dis) begin
                        held_q <= held_q || ev;
                    end else begin
                        held_q <= 1'b0;
                    end
                    if (!m1_act && (ev || held_q) && !dis) begin
                        ip_q <= 1'b1;
                    end else if (ack_me || dis) begin
                        ip_q <= 1'b0;
                    end
                    if (ack_me) begin
                        ius_q <= 1'b1;
                    end else if (done_me) begin
                        ius_q <= 1'b0;
                    end
                end
            end

            assign ip[g] = ip_q;
            assign ius[g] = ius_q;
            assign tcn[g] = tc_next_q;
            assign zc[g] = zc_q;
            assign cnt_all[8*g+7:8*g] = cnt_q;
            assign en[g+1] = en[g] && !ius_q && !ip_q;
        end
    endgenerate

    reg [7:0] rd_mux;
    always @* begin
        case (bus_cs)
            2'd0: rd_mux = cnt_all[7:0];
            2'd1: rd_mux = cnt_all[15:8];
            2'd2: rd_mux = cnt_all[23:16];
            default: rd_mux = cnt_all[31:24];
        endcase
    end

    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            vec_q <= `FCCT_VEC_RST;
            o_data <= 8'h00;
            o_data_oe <= 1'b0;
            o_int_request_n <= 1'b1;
            o_chain_enable_out <= 1'b0;
            o_zero_count_pulse <= 4'h0;
        end else if (i_ce) begin
            if (vec_wr) begin
                vec_q <= bus_d[`FCCT_VEC_BASE_HI:`FCCT_VEC_BASE_LO];
            end
            if (rd_stb) begin
                o_data <= rd_mux;
                o_data_oe <= 1'b1;
            end else if (ack_stb && ack_ok) begin
                o_data <= {vec_q, ack_idx, 1'b0};
                o_data_oe <= 1'b1;
            end else if (!rd_act && !ack_act) begin
                o_data_oe <= 1'b0;
            end
            o_int_request_n <= !(|(ip & en[NCH-1:0]));
            o_chain_enable_out <= en[NCH];
            o_zero_count_pulse <= zc;
        end
    end
endmodule

// file: src/fcct_defs.vh
`ifndef FCCT_DEFS_VH
`define FCCT_DEFS_VH

// Channel control word bit positions.
`define FCCT_CW_CTRL 0
`define FCCT_CW_RESET 1
`define FCCT_CW_TCNEXT 2
`define FCCT_CW_TRIG 3
`define FCCT_CW_EDGE 4
`define FCCT_CW_PRE 5
`define FCCT_CW_MODE 6
`define FCCT_CW_INTEN 7

// Vector layout: base in bits 7..3, channel code in bits 2..1, bit 0 zero.
`define FCCT_VEC_BASE_HI 7
`define FCCT_VEC_BASE_LO 3

// Reset values.
`define FCCT_CTRL_RST 8'h00
`define FCCT_TC_RST 8'h00
`define FCCT_VEC_RST 5'h00

// Down counter step values; a loaded 8'h00 counts 256 steps.
`define FCCT_CNT_ONE 8'h01

// Prescaler terminal counts for factors of 16 and 256.
`define FCCT_PRE_SHORT_LAST 8'h0f
`define FCCT_PRE_LONG_LAST 8'hff

`endif

// file: src/fcct_sync.v
`timescale 1ns/1ps
// Two-flop synchroniser for pins that arrive from outside the clock domain.
module fcct_sync #(
    parameter W = 8
) (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_ce,
    input wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else if (i_ce) begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule

// file: src/fcct_presc.v
`timescale 1ns/1ps
`include "fcct_defs.vh"
// Timer-mode prescaler: one tick every 16 or 256 enabled clocks while running.
module fcct_presc (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_ce,
    input wire i_run,
    input wire i_sel256,
    output wire o_tick
);
    reg [7:0] cnt_q;
    reg tick_q;
    wire [7:0] last = i_sel256 ? `FCCT_PRE_LONG_LAST : `FCCT_PRE_SHORT_LAST;

    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            cnt_q <= 8'h00;
            tick_q <= 1'b0;
        end else if (i_ce) begin
            if (!i_run) begin
                cnt_q <= 8'h00;
                tick_q <= 1'b0;
            end else if (cnt_q >= last) begin
                cnt_q <= 8'h00;
                tick_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 8'h01;
                tick_q <= 1'b0;
            end
        end
    end

    assign o_tick = tick_q;
endmodule

// file: bench/fcct_checker.sv
`timescale 1ns/1ps
module fcct_checker (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_io_request_n,
    input wire i_machine_cycle_one_n,
    input wire i_chain_enable_in,
    input wire [7:0] o_data,
    input wire o_data_oe,
    input wire o_int_request_n,
    input wire o_chain_enable_out,
    input wire [3:0] o_zero_count_pulse
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    // Pins pass a two-flop synchroniser, so answers trail the pins by three edges.
    AST_OE_CAUSE: assert property ($rose(o_data_oe) |-> !$past(i_io_request_n, 3))
        else $error("data bus driven without a request");
    AST_OE_RELEASE: assert property ($rose(i_io_request_n) |-> ##[1:4] !o_data_oe)
        else $error("data bus not released");
    AST_VEC_BIT0: assert property (o_data_oe && !i_machine_cycle_one_n |-> !o_data[0])
        else $error("vector bit 0 not clear");
    AST_ACK_NEEDS_INT: assert property (
        $rose(o_data_oe) && !i_machine_cycle_one_n |-> !$past(o_int_request_n, 2))
        else $error("vector driven with nothing pending");
    AST_CHAIN_BLOCK: assert property ((!i_chain_enable_in)[*4] |=> !o_chain_enable_out)
        else $error("chain enable passed on while blocked");
    AST_CHAIN_NO_VEC: assert property (
        (!i_chain_enable_in && !i_machine_cycle_one_n)[*4] |=> !o_data_oe)
        else $error("vector driven while chain disabled");
    AST_PULSE_ONE: assert property ((o_zero_count_pulse & $past(o_zero_count_pulse)) == 4'h0)
        else $error("zero count pulse longer than one cycle");
    AST_INT_FROZEN: assert property (
        (!i_machine_cycle_one_n && i_io_request_n)[*4] |=> $stable(o_int_request_n))
        else $error("request changed during machine cycle one");
    cover property ($rose(o_data_oe) && !i_machine_cycle_one_n);
    cover property (|o_zero_count_pulse);
    cover property ($fell(o_int_request_n));
endmodule

// file: bench/fcct_host.sv
`timescale 1ns/1ps
// Processor side: strobes move on falling edges and stand for a fixed count of them, answer or not.
module fcct_host (
    input wire i_ref_clk,
    input wire [7:0] i_data,
    input wire i_data_oe,
    output logic o_chip_enable_n,
    output logic o_read_n,
    output logic o_machine_cycle_one_n,
    output logic o_io_request_n,
    output logic o_channel_select_high,
    output logic o_channel_select_low,
    output logic [7:0] o_data
);
    initial begin
        {o_chip_enable_n, o_read_n, o_machine_cycle_one_n, o_io_request_n} = 4'hf;
        {o_channel_select_high, o_channel_select_low, o_data} = 10'h000;
    end
    task automatic put(input logic [3:0] s, input logic [1:0] ch, input logic [7:0] d);
        @(negedge i_ref_clk);
        {o_chip_enable_n, o_read_n, o_machine_cycle_one_n, o_io_request_n} = s;
        {o_channel_select_high, o_channel_select_low} = ch;
        o_data = d;
    endtask
    // A released bus shows the inverse of its last value, never a stale copy.
    task automatic idle(input int n);
        put(4'hf, 2'h0, ~o_data);
        repeat (n) @(negedge i_ref_clk);
    endtask
    task automatic wr(input logic [1:0] ch, input logic [7:0] d);
        put(4'hf, ch, d);
        put(4'h6, ch, d);
        repeat (4) @(negedge i_ref_clk);
        idle(3);
    endtask
    // The level held through the low phase is what the next rising edge samples.
    task automatic grab(output logic [7:0] v, output logic ok);
        ok = 1'b0;
        v = 8'h00;
        repeat (8) begin
            @(negedge i_ref_clk);
            if (!ok && i_data_oe === 1'b1) begin
                ok = 1'b1;
                v = i_data;
            end
        end
        idle(4);
    endtask
    task automatic rd(input logic [1:0] ch, output logic [7:0] v, output logic ok);
        put(4'h2, ch, ~o_data);
        grab(v, ok);
    endtask
    task automatic ack(output logic [7:0] v, output logic ok);
        put(4'hd, 2'h0, ~o_data);
        repeat (3) @(negedge i_ref_clk);
        put(4'hc, 2'h0, o_data);
        grab(v, ok);
    endtask
endmodule

// file: bench/fcct_core_tb.sv
`timescale 1ns/1ps
module fcct_core_tb;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic sdone = 1'b0;
    logic chain_in = 1'b1;
    logic [3:0] trig = 4'h0;
    wire ce_n, rd_n, m1_n, io_request_n_n, cs_lo, cs_hi, oe, int_n, chain_out;
    wire [7:0] hd, dd;
    wire [3:0] zc;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    int pc [4] = '{default: 0};
    int n;
    logic [7:0] v;
    logic ok;
    always #2.5 i_ref_clk = ~i_ref_clk;
    fcct_host fcct_host_inst (.i_ref_clk(i_ref_clk), .i_data(dd), .i_data_oe(oe),
        .o_chip_enable_n(ce_n), .o_read_n(rd_n), .o_machine_cycle_one_n(m1_n),
        .o_io_request_n(io_request_n_n), .o_channel_select_high(cs_hi),
        .o_channel_select_low(cs_lo), .o_data(hd));
    fcct_core fcct_core_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(1'b1),
        .i_chip_enable_n(ce_n), .i_io_request_n(io_request_n_n), .i_read_n(rd_n),
        .i_machine_cycle_one_n(m1_n), .i_channel_select_low(cs_lo),
        .i_channel_select_high(cs_hi), .i_data(hd), .i_chain_enable_in(chain_in),
        .i_service_done(sdone), .i_ext_clock_trigger(trig), .o_data(dd), .o_data_oe(oe),
        .o_int_request_n(int_n), .o_chain_enable_out(chain_out), .o_zero_count_pulse(zc));
    task tally_and_finish;
        $display("checked %0d failed %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(negedge i_ref_clk) begin
        cycles++;
        for (int i = 0; i < 4; i++) begin
            pc[i] += int'(zc[i] === 1'b1);
        end
        if (cycles == 40000) begin
            failures++;
            tally_and_finish();
        end
    end
    task chk(input string s, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %0h seen %0h", s, e, g);
        end
    endtask
    task done(input string s);
        $display("test %s finished", s);
    endtask
    task kick(input logic [3:0] m, input int k);
        repeat (k) begin
            @(negedge i_ref_clk);
            trig = trig ^ m;
            repeat (3) @(negedge i_ref_clk);
            trig = trig ^ m;
            repeat (3) @(negedge i_ref_clk);
        end
        repeat (4) @(negedge i_ref_clk);
    endtask
    task svc;
        @(negedge i_ref_clk);
        sdone = 1'b1;
        repeat (3) @(negedge i_ref_clk);
        sdone = 1'b0;
        repeat (4) @(negedge i_ref_clk);
    endtask
    // Bounded, so a silent channel ends in a mismatch rather than a hang.
    task gap(input int c);
        n = 0;
        while (zc[c] !== 1'b1 && n < 9000) begin
            @(negedge i_ref_clk);
            n++;
        end
        n = 0;
        do begin
            @(negedge i_ref_clk);
            n++;
        end while (zc[c] !== 1'b1 && n < 9000);
    endtask
    initial begin
        repeat (2) @(negedge i_ref_clk);
        i_rst = 1'b0;
        fcct_host_inst.wr(2'h0, 8'hae);
        fcct_host_inst.wr(2'h1, 8'h50);
        fcct_host_inst.wr(2'h0, 8'hd1);
        kick(4'h1, 3);
        chk("idle pulses", 16'h0, 16'(pc[0]));
        done("no constant");
        fcct_host_inst.wr(2'h0, 8'hd5);
        fcct_host_inst.wr(2'h0, 8'h03);
        kick(4'h1, 6);
        chk("zero pulses", 16'h2, 16'(pc[0]));
        chk("int request", 16'h0, {15'h0, int_n});
        fcct_host_inst.rd(2'h0, v, ok);
        chk("count read", 16'h0103, {7'h0, ok, v});
        fcct_host_inst.ack(v, ok);
        chk("vector ch0", 16'h01a8, {7'h0, ok, v});
        chk("int cleared", 16'h1, {15'h0, int_n});
        svc;
        done("counter");
        fcct_host_inst.wr(2'h1, 8'hd5);
        fcct_host_inst.wr(2'h1, 8'h01);
        fcct_host_inst.wr(2'h2, 8'hd5);
        fcct_host_inst.wr(2'h2, 8'h01);
        kick(4'h6, 1);
        fcct_host_inst.ack(v, ok);
        chk("vector ch1", 16'h01aa, {7'h0, ok, v});
        fcct_host_inst.ack(v, ok);
        chk("blocked ack", 16'h0000, {7'h0, ok, v});
        svc;
        fcct_host_inst.ack(v, ok);
        chk("vector ch2", 16'h01ac, {7'h0, ok, v});
        svc;
        done("priority");
        chain_in = 1'b0;
        kick(4'h2, 1);
        chk("chain out", 16'h0, {15'h0, chain_out});
        fcct_host_inst.ack(v, ok);
        chk("chain ack", 16'h0000, {7'h0, ok, v});
        chain_in = 1'b1;
        fcct_host_inst.ack(v, ok);
        chk("chain vector", 16'h01aa, {7'h0, ok, v});
        svc;
        chk("chain open", 16'h1, {15'h0, chain_out});
        kick(4'h2, 1);
        chk("int raised", 16'h0, {15'h0, int_n});
        fcct_host_inst.wr(2'h1, 8'h51);
        chk("int dropped", 16'h1, {15'h0, int_n});
        done("chain and disable");
        fcct_host_inst.wr(2'h2, 8'h05);
        fcct_host_inst.wr(2'h2, 8'h02);
        gap(2);
        chk("timer period", 16'h20, 16'(n));
        fcct_host_inst.wr(2'h2, 8'h05);
        fcct_host_inst.wr(2'h2, 8'h04);
        gap(2);
        chk("late reload", 16'h40, 16'(n));
        fcct_host_inst.wr(2'h2, 8'h21);
        gap(2);
        chk("long prescale", 16'h400, 16'(n));
        fcct_host_inst.wr(2'h2, 8'h07);
        n = pc[2];
        repeat (300) @(negedge i_ref_clk);
        chk("stopped", 16'h0, 16'(pc[2] - n));
        fcct_host_inst.wr(2'h2, 8'h00);
        gap(2);
        chk("count 256", 16'h1000, 16'(n));
        fcct_host_inst.wr(2'h3, 8'h0d);
        fcct_host_inst.wr(2'h3, 8'h01);
        n = pc[3];
        repeat (100) @(negedge i_ref_clk);
        chk("armed idle", 16'h0, 16'(pc[3] - n));
        kick(4'h8, 1);
        gap(3);
        chk("trigger period", 16'h10, 16'(n));
        done("timer");
        tally_and_finish();
    end
endmodule
bind fcct_core fcct_checker fcct_checker_inst (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_io_request_n(i_io_request_n),
    .i_machine_cycle_one_n(i_machine_cycle_one_n), .i_chain_enable_in(i_chain_enable_in),
    .o_data(o_data), .o_data_oe(o_data_oe), .o_int_request_n(o_int_request_n),
    .o_chain_enable_out(o_chain_enable_out), .o_zero_count_pulse(o_zero_count_pulse));
